// *** core/psc_pkg.sv ***
/*
  constants shared by the power-supply sequence and configuration block:
  command codes, value limits, reset values and timing figures.
  assumes values arrive as plain unsigned integers (ms, V, 0.1 V units).
*/
`default_nettype none
package psc_pkg;
  // ***************************
  // command codes
  // ***************************
  localparam logic [7:0] CMD_STORE_ALL = 8'h15;
  localparam logic [7:0] CMD_AC_START  = 8'h35;
  localparam logic [7:0] CMD_AC_STOP   = 8'h36;
  localparam logic [7:0] CMD_VIN_MON   = 8'h88;
  localparam logic [7:0] CMD_ROLE_SEL  = 8'hD5;
  localparam logic [7:0] CMD_FAN       = 8'hD6;
  localparam logic [7:0] CMD_RC_DELAY  = 8'hD9;
  localparam logic [7:0] CMD_VIN_DELAY = 8'hDA;
  localparam logic [7:0] CMD_SLEW      = 8'hDB;
  localparam logic [7:0] CMD_AUX       = 8'hDC;
  localparam logic [7:0] CMD_DC_START  = 8'hDD;
  localparam logic [7:0] CMD_DC_STOP   = 8'hDE;
  localparam logic [7:0] CMD_FREQ_MON  = 8'hE9;
  localparam logic [7:0] CMD_ROLE_RB   = 8'hEC;
  // ***************************
  // limits and reset values
  // ***************************
  localparam logic [15:0] RC_DELAY_MAX   = 16'h0F3C;
  localparam logic [15:0] RC_DELAY_RST   = 16'h0000;
  localparam logic [15:0] START_SPEC_MS  = 16'h01F4;
  localparam logic [15:0] VIN_DELAY_MAX  = 16'hFA00;
  localparam logic [15:0] AC_START_MIN   = 16'h003C;
  localparam logic [15:0] AC_START_MAX   = 16'h00F0;
  localparam logic [15:0] AC_STOP_MIN    = 16'h0032;
  localparam logic [15:0] AC_STOP_MAX    = 16'h00C8;
  localparam logic [15:0] AC_GAP         = 16'h0005;
  localparam logic [15:0] AC_START_RST   = 16'h0055;
  localparam logic [15:0] AC_STOP_RST    = 16'h004B;
  localparam logic [15:0] DC_START_MIN   = 16'h0050;
  localparam logic [15:0] DC_START_MAX   = 16'h0154;
  localparam logic [15:0] DC_STOP_MIN    = 16'h0046;
  localparam logic [15:0] DC_STOP_MAX    = 16'h0118;
  localparam logic [15:0] DC_GAP         = 16'h000A;
  localparam logic [15:0] DC_START_RST   = 16'h0078;
  localparam logic [15:0] DC_STOP_RST    = 16'h0064;
  localparam logic [15:0] AUX_MIN        = 16'h002F;
  localparam logic [15:0] AUX_MAX        = 16'h007E;
  localparam logic [15:0] AUX_RST        = 16'h0078;
  localparam logic [1:0]  SLEW_RST       = 2'h0;
  localparam logic [1:0]  ROLE_RST       = 2'h0;
  localparam logic [1:0]  ROLE_MASTER    = 2'h1;
  localparam logic [1:0]  ROLE_SLAVE     = 2'h3;
  // ***************************
  // timing
  // ***************************
  localparam int          CLK_PERIOD_NS  = 25;
  localparam int          MS_NS          = 1000000;
  localparam int          MS_CYCLES      = MS_NS / CLK_PERIOD_NS;
  localparam logic [16:0] INT_DELAY_MS   = 17'h0_02BC;
  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_WAIT = 2'b01,
    ST_ON   = 2'b10
  } psc_state_t;
endpackage : psc_pkg
`default_nettype wire

// *** core/psc_config_regs.sv ***
/*
  command-register bank and start-up sequencer of a power-supply target.
  assumes a command decoder on the same clock presents one command per
  i_cmd_valid pulse; pins are asynchronous and synchronised here.
*/
// What this block does
// - remote-on delay 0..3900 ms, default 0
// - bus on-command uses same remote-on delay
// - pin on at power-up adds 700 ms
// - input-on delay start-spec..64000 ms
// - both delays apply: wait the larger
// - deferred settings load only at start-up
// - slew byte: bits 1-0 writable only
// - slew code drives all output ramps
// - ac start 60..240, above stop+5
// - ac stop 50..200, below start-5
// - dc start 80..340, above stop+10
// - dc stop 70..280, below start-10
// - fan byte bit0: auto or maximum
// - aux setpoint up to 12.6 V, default 12
// - role select: pin, master or slave
// - role readback bit0: slave is one
// - input voltage monitor returns rms value
// - frequency monitor reads zero on dc
// - store copies deferred settings to nonvolatile copy
`timescale 1ns/1ps
`default_nettype none
module psc_config_regs
  import psc_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_CYCLES
) (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_cmd_valid,
  input  wire logic        i_cmd_write,
  input  wire logic [7:0]  i_cmd_code,
  input  wire logic [15:0] i_cmd_data,
  output var  logic        o_rsp_valid,
  output var  logic        o_rsp_error,
  output var  logic [15:0] o_rsp_data,
  input  wire logic        i_input_power_pin,
  input  wire logic        i_remote_control_pin,
  input  wire logic        i_follower_select_pin,
  input  wire logic        i_bus_on_request,
  input  wire logic [15:0] i_vin_rms,
  input  wire logic [15:0] i_vin_freq,
  input  wire logic        i_input_is_dc,
  output var  logic        o_output_start,
  output var  logic [1:0]  o_slew_code,
  output var  logic        o_fan_max,
  output var  logic [15:0] o_aux_setpoint,
  output var  logic        o_role_slave,
  output var  logic [15:0] o_ac_start_level,
  output var  logic [15:0] o_ac_stop_level,
  output var  logic [15:0] o_dc_start_level,
  output var  logic [15:0] o_dc_stop_level
);
  // ***************************
  // helpers
  // ***************************
  function automatic logic in_range(input logic [15:0] v,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  // widened so that level plus gap cannot wrap
  function automatic logic above(input logic [15:0] a,
                                 input logic [15:0] b,
                                 input logic [15:0] gap);
    above = {1'b0, a} > ({1'b0, b} + {1'b0, gap});
  endfunction : above

  function automatic logic [16:0] sat_inc(input logic [16:0] v);
    sat_inc = (&v) ? v : v + 17'h0_0001;
  endfunction : sat_inc

  // ***************************
  // pin synchronisers
  // ***************************
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic       pwr_q_reg;
  logic       pwr_on;
  logic       rc_on;
  logic       follower_on;
  logic       pwr_rise;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      pwr_q_reg <= 1'b0;
    end else begin
      sync1_reg <= {i_follower_select_pin, i_remote_control_pin,
                    i_input_power_pin};
      sync2_reg <= sync1_reg;
      pwr_q_reg <= sync2_reg[0];
    end
  end

  assign pwr_on      = sync2_reg[0];
  assign rc_on       = sync2_reg[1];
  assign follower_on = sync2_reg[2];
  assign pwr_rise    = pwr_on & ~pwr_q_reg;

  // ***************************
  // command decode
  // ***************************
  logic [15:0] rc_delay_reg, vin_delay_reg, ac_start_reg, ac_stop_reg;
  logic [15:0] dc_start_reg, dc_stop_reg, aux_reg;
  logic [1:0]  slew_reg, role_reg;
  logic        fan_reg;
  logic        hit, ok, ro, send, err, wr_take;
  logic [15:0] rd_data;
  logic [15:0] d;

  assign d = i_cmd_data;

  always_comb begin
    hit     = 1'b1;
    ok      = 1'b1;
    ro      = 1'b0;
    send    = 1'b0;
    rd_data = 16'h0000;
    case (i_cmd_code)
      CMD_RC_DELAY: begin
        ok      = d <= RC_DELAY_MAX;
        rd_data = rc_delay_reg;
      end
      CMD_VIN_DELAY: begin
        ok      = in_range(d, START_SPEC_MS, VIN_DELAY_MAX);
        rd_data = vin_delay_reg;
      end
      CMD_SLEW: rd_data = {14'h0000, slew_reg};
      CMD_AC_START: begin
        ok = in_range(d, AC_START_MIN, AC_START_MAX)
             && above(d, ac_stop_reg, AC_GAP);
        rd_data = ac_start_reg;
      end
      CMD_AC_STOP: begin
        ok = in_range(d, AC_STOP_MIN, AC_STOP_MAX)
             && above(ac_start_reg, d, AC_GAP);
        rd_data = ac_stop_reg;
      end
      CMD_DC_START: begin
        ok = in_range(d, DC_START_MIN, DC_START_MAX)
             && above(d, dc_stop_reg, DC_GAP);
        rd_data = dc_start_reg;
      end
      CMD_DC_STOP: begin
        ok = in_range(d, DC_STOP_MIN, DC_STOP_MAX)
             && above(dc_start_reg, d, DC_GAP);
        rd_data = dc_stop_reg;
      end
      CMD_FAN: rd_data = {15'h0000, fan_reg};
      CMD_AUX: begin
        ok      = in_range(d, AUX_MIN, AUX_MAX);
        rd_data = aux_reg;
      end
      CMD_ROLE_SEL: rd_data = {14'h0000, role_reg};
      CMD_ROLE_RB: begin
        ro      = 1'b1;
        rd_data = {15'h0000, o_role_slave};
      end
      CMD_VIN_MON: begin
        ro      = 1'b1;
        rd_data = i_vin_rms;
      end
      CMD_FREQ_MON: begin
        ro      = 1'b1;
        rd_data = i_input_is_dc ? 16'h0000 : i_vin_freq;
      end
      CMD_STORE_ALL: send = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // a refused write changes nothing and answers with an error
  assign err = ~hit | (i_cmd_write & (ro | ~ok))
               | (~i_cmd_write & send);
  assign wr_take = i_cmd_valid & i_cmd_write & ~err;

  // ***************************
  // response
  // ***************************
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_rsp_valid <= 1'b0;
      o_rsp_error <= 1'b0;
      o_rsp_data  <= 16'h0000;
    end else begin
      o_rsp_valid <= i_cmd_valid;
      o_rsp_error <= i_cmd_valid & err;
      o_rsp_data  <= (i_cmd_valid & ~i_cmd_write & ~err) ? rd_data
                                                        : 16'h0000;
    end
  end

  // ***************************
  // working settings
  // ***************************
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rc_delay_reg  <= RC_DELAY_RST;
      vin_delay_reg <= START_SPEC_MS;
      ac_start_reg  <= AC_START_RST;
      ac_stop_reg   <= AC_STOP_RST;
      dc_start_reg  <= DC_START_RST;
      dc_stop_reg   <= DC_STOP_RST;
      aux_reg       <= AUX_RST;
      slew_reg      <= SLEW_RST;
      role_reg      <= ROLE_RST;
      fan_reg       <= 1'b0;
    end else if (wr_take) begin
      case (i_cmd_code)
        CMD_RC_DELAY:  rc_delay_reg  <= d;
        CMD_VIN_DELAY: vin_delay_reg <= d;
        CMD_AC_START:  ac_start_reg  <= d;
        CMD_AC_STOP:   ac_stop_reg   <= d;
        CMD_DC_START:  dc_start_reg  <= d;
        CMD_DC_STOP:   dc_stop_reg   <= d;
        CMD_AUX:       aux_reg       <= d;
        CMD_SLEW:      slew_reg      <= d[1:0];
        CMD_ROLE_SEL:  role_reg      <= d[1:0];
        CMD_FAN:       fan_reg       <= d[0];
        default: ;
      endcase
    end
  end

  // ***************************
  // nonvolatile image and start-up load
  // ***************************
  // the image only models the stored copy; real retention is outside
  logic [15:0] nv_vin_delay, nv_ac_start, nv_ac_stop;
  logic [15:0] nv_dc_start, nv_dc_stop, act_vin_delay;
  logic [1:0]  nv_role, act_role;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      nv_vin_delay <= START_SPEC_MS;
      nv_ac_start  <= AC_START_RST;
      nv_ac_stop   <= AC_STOP_RST;
      nv_dc_start  <= DC_START_RST;
      nv_dc_stop   <= DC_STOP_RST;
      nv_role      <= ROLE_RST;
    end else if (wr_take && send) begin
      nv_vin_delay <= vin_delay_reg;
      nv_ac_start  <= ac_start_reg;
      nv_ac_stop   <= ac_stop_reg;
      nv_dc_start  <= dc_start_reg;
      nv_dc_stop   <= dc_stop_reg;
      nv_role      <= role_reg;
    end
  end

  // deferred values change only as input power comes up
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      act_vin_delay    <= START_SPEC_MS;
      o_ac_start_level <= AC_START_RST;
      o_ac_stop_level  <= AC_STOP_RST;
      o_dc_start_level <= DC_START_RST;
      o_dc_stop_level  <= DC_STOP_RST;
      act_role         <= ROLE_RST;
    end else if (pwr_rise) begin
      act_vin_delay    <= nv_vin_delay;
      o_ac_start_level <= nv_ac_start;
      o_ac_stop_level  <= nv_ac_stop;
      o_dc_start_level <= nv_dc_start;
      o_dc_stop_level  <= nv_dc_stop;
      act_role         <= nv_role;
    end
  end

  // ***************************
  // millisecond timers
  // ***************************
  logic [15:0] tick_cnt;
  logic        ms_tick;
  logic [16:0] power_ms, req_ms, extra_ms;
  logic        req_on;

  assign ms_tick = tick_cnt == 16'(MS_TICK_CYCLES - 1);
  assign req_on  = rc_on | i_bus_on_request;

  always_ff @(posedge i_clock) begin
    if (i_reset || ms_tick)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset || !pwr_on)
      power_ms <= 17'h0_0000;
    else if (ms_tick)
      power_ms <= sat_inc(power_ms);
  end

  always_ff @(posedge i_clock) begin
    if (i_reset || !pwr_on || !req_on)
      req_ms <= 17'h0_0000;
    else if (ms_tick)
      req_ms <= sat_inc(req_ms);
  end

  always_ff @(posedge i_clock) begin
    if (i_reset || !req_on)
      extra_ms <= 17'h0_0000;
    else if (pwr_rise)
      extra_ms <= INT_DELAY_MS;
  end

  // ***************************
  // start-up sequencer
  // ***************************
  // both timers must expire, so the longer delay governs
  logic       ready;
  psc_state_t state_reg, state_next;

  assign ready = (power_ms >= {1'b0, act_vin_delay} + extra_ms)
                 && (req_ms >= {1'b0, rc_delay_reg} + extra_ms);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF:  if (pwr_on && req_on) state_next = ST_WAIT;
      ST_WAIT: if (ready) state_next = ST_ON;
      ST_ON:   state_next = ST_ON;
      default: state_next = ST_OFF;
    endcase
    if (!pwr_on || !req_on)
      state_next = ST_OFF;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg      <= ST_OFF;
      o_output_start <= 1'b0;
    end else begin
      state_reg      <= state_next;
      o_output_start <= state_next == ST_ON;
    end
  end

  // ***************************
  // accessory outputs
  // ***************************
  logic role_next;

  always_comb begin
    case (act_role)
      ROLE_MASTER: role_next = 1'b0;
      ROLE_SLAVE:  role_next = 1'b1;
      default:     role_next = follower_on;
    endcase
  end

  // one slew code for power-on, remote, trim pin and voltage command
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_slew_code    <= SLEW_RST;
      o_fan_max      <= 1'b0;
      o_aux_setpoint <= AUX_RST;
      o_role_slave   <= 1'b0;
    end else begin
      o_slew_code    <= slew_reg;
      o_fan_max      <= fan_reg;
      o_aux_setpoint <= aux_reg;
      o_role_slave   <= role_next;
    end
  end

  // ***************************
  // assertions
  // ***************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_wr(logic [7:0] c);
    i_cmd_valid && i_cmd_write && i_cmd_code == c;
  endsequence

  sequence s_rd(logic [7:0] c);
    i_cmd_valid && !i_cmd_write && i_cmd_code == c;
  endsequence

  rc_range_a: assert property (
    s_wr(CMD_RC_DELAY) ##0 (d > RC_DELAY_MAX)
    |=> o_rsp_error && rc_delay_reg == $past(rc_delay_reg))
    else $error("remote delay above range accepted");
  ac_start_chk_a: assert property (
    s_wr(CMD_AC_START) ##0 ({1'b0, d} <= {1'b0, ac_stop_reg} + 17'h5)
    |=> o_rsp_error)
    else $error("ac start too close to stop accepted");
  ac_stop_chk_a: assert property (
    s_wr(CMD_AC_STOP) ##0 ({1'b0, d} + 17'h5 >= {1'b0, ac_start_reg})
    |=> o_rsp_error)
    else $error("ac stop too close to start accepted");
  dc_start_chk_a: assert property (
    s_wr(CMD_DC_START) ##0 ({1'b0, d} <= {1'b0, dc_stop_reg} + 17'hA)
    |=> o_rsp_error)
    else $error("dc start too close to stop accepted");
  dc_stop_chk_a: assert property (
    s_wr(CMD_DC_STOP) ##0 ({1'b0, d} + 17'hA >= {1'b0, dc_start_reg})
    |=> o_rsp_error)
    else $error("dc stop too close to start accepted");
  reject_keep_a: assert property (
    i_cmd_valid && i_cmd_write && err
    |=> $stable(ac_start_reg) && $stable(ac_stop_reg)
        && $stable(dc_start_reg) && $stable(dc_stop_reg))
    else $error("refused write changed a threshold");
  slew_read_a: assert property (
    s_rd(CMD_SLEW) |=> o_rsp_data[15:2] == 14'h0000)
    else $error("slew upper bits not zero");
  fan_read_a: assert property (
    s_rd(CMD_FAN) |=> o_rsp_data == {15'h0000, $past(fan_reg)})
    else $error("fan byte readback wrong");
  role_force_a: assert property (
    (act_role == ROLE_SLAVE)[*2] |-> o_role_slave)
    else $error("forced slave role not applied");
  role_rb_a: assert property (
    s_rd(CMD_ROLE_RB) |=> o_rsp_data == {15'h0000, $past(o_role_slave)})
    else $error("role readback mismatch");
  freq_dc_a: assert property (
    s_rd(CMD_FREQ_MON) ##0 i_input_is_dc |=> o_rsp_data == 16'h0000)
    else $error("frequency not zero on dc input");
  deferred_a: assert property (
    !pwr_rise |=> $stable(o_ac_start_level) && $stable(act_vin_delay))
    else $error("deferred setting changed outside start-up");
  start_wait_a: assert property (
    $rose(o_output_start) |-> $past(ready) && $past(pwr_on))
    else $error("output started before delays ran out");
endmodule : psc_config_regs
`default_nettype wire

// *** test/psc_host_model.sv ***
/*
  host controller model: issues one register command at a time and
  collects the one-cycle answer.
  assumes the bench shares the block's clock with it.
*/
`timescale 1ns/1ps
`default_nettype none
module psc_host_model
  import psc_pkg::*;
(
  input  wire logic        i_clock,
  output var  logic        o_cmd_valid,
  output var  logic        o_cmd_write,
  output var  logic [7:0]  o_cmd_code,
  output var  logic [15:0] o_cmd_data,
  input  wire logic        i_rsp_valid,
  input  wire logic        i_rsp_error,
  input  wire logic [15:0] i_rsp_data
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_write = 1'b0;
    o_cmd_code  = 8'h00;
    o_cmd_data  = 16'h0000;
  end
  // ***************************
  // command transfer
  // ***************************
  // released fields are inverted so a stale value never looks valid
  task automatic xfer(input logic wr, input logic [7:0] code,
                      input logic [15:0] data, output logic seen,
                      output logic err, output logic [15:0] rd);
    seen = 1'b0;
    err  = 1'b0;
    rd   = 16'h0000;
    @(negedge i_clock);
    o_cmd_valid = 1'b1;
    o_cmd_write = wr;
    o_cmd_code  = code;
    o_cmd_data  = data;
    for (int n = 0; n < 4 && seen !== 1'b1; n++) begin
      @(negedge i_clock);
      o_cmd_valid = 1'b0;
      o_cmd_write = ~wr;
      o_cmd_code  = ~code;
      o_cmd_data  = ~data;
      if (i_rsp_valid === 1'b1) begin
        seen = 1'b1;
        err  = i_rsp_error;
        rd   = i_rsp_data;
      end
    end
  endtask : xfer
  // deferred settings only survive a power cycle once stored
  task automatic store(output logic seen, output logic err);
    logic [15:0] rd;
    xfer(1'b1, CMD_STORE_ALL, 16'h0000, seen, err, rd);
  endtask : store
endmodule : psc_host_model
`default_nettype wire

// *** test/psc_config_regs_tb.sv ***
/*
  self-checking bench for the command-register bank and sequencer.
  assumes a 40 MHz clock and a shortened millisecond tick of 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module psc_config_regs_tb;
  import psc_pkg::*;
  localparam int TICK = 4;
  logic        i_clock, i_reset, cmd_valid, cmd_write;
  logic        rsp_valid, rsp_error, pwr, rc_pin, fol_pin, bus_on;
  logic        is_dc, out_start, fan_max, role_slave, seen, err;
  logic [7:0]  cmd_code;
  logic [1:0]  slew;
  logic [15:0] cmd_data, rsp_data, vin_rms, vin_freq, aux;
  logic [15:0] ac_on, ac_off, dc_on, dc_off;
  int          err_total, checks;
  initial i_clock = 1'b0;
  always #12.5 i_clock = ~i_clock;
  psc_host_model host (.i_clock(i_clock), .o_cmd_valid(cmd_valid),
    .o_cmd_write(cmd_write), .o_cmd_code(cmd_code),
    .o_cmd_data(cmd_data), .i_rsp_valid(rsp_valid),
    .i_rsp_error(rsp_error), .i_rsp_data(rsp_data));
  psc_config_regs #(.MS_TICK_CYCLES(TICK)) dut (.i_clock(i_clock),
    .i_reset(i_reset), .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write),
    .i_cmd_code(cmd_code), .i_cmd_data(cmd_data),
    .o_rsp_valid(rsp_valid), .o_rsp_error(rsp_error),
    .o_rsp_data(rsp_data), .i_input_power_pin(pwr),
    .i_remote_control_pin(rc_pin), .i_follower_select_pin(fol_pin),
    .i_bus_on_request(bus_on), .i_vin_rms(vin_rms),
    .i_vin_freq(vin_freq), .i_input_is_dc(is_dc),
    .o_output_start(out_start), .o_slew_code(slew), .o_fan_max(fan_max),
    .o_aux_setpoint(aux), .o_role_slave(role_slave),
    .o_ac_start_level(ac_on), .o_ac_stop_level(ac_off),
    .o_dc_start_level(dc_on), .o_dc_stop_level(dc_off));
  // ***************************
  // shared tasks
  // ***************************
  task automatic results();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  task automatic chk(input string name, input logic [15:0] exp,
                     input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic cmd(input logic is_wr, input logic [7:0] code,
                     input logic [15:0] data, input logic exp_err,
                     input logic [15:0] exp_rd);
    logic [15:0] got;
    host.xfer(is_wr, code, data, seen, err, got);
    chk($sformatf("answer %h", code), 16'h0001, {15'h0000, seen});
    if (seen !== 1'b1) results();
    chk($sformatf("error %h", code), {15'h0000, exp_err}, {15'h0000, err});
    if (is_wr === 1'b0) chk($sformatf("data %h", code), exp_rd, got);
  endtask : cmd
  task automatic wr(input logic [7:0] c, input logic [15:0] d,
                    input logic e);
    cmd(1'b1, c, d, e, 16'h0000);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    cmd(1'b0, c, 16'h0000, 1'b0, exp);
  endtask : rd
  // a bounded wait that runs out also ends the run
  task automatic start_in(input int ms);
    int n;
    n = 0;
    while (out_start !== 1'b1 && n < ms * TICK + 40) begin
      @(negedge i_clock);
      n++;
    end
    checks++;
    if (n < ms * TICK - 8 || n > ms * TICK + 16) begin
      err_total++;
      $display("CHECK FAILED start delay expected %0d seen %0d",
               ms * TICK, n);
    end
    if (n >= ms * TICK + 40) results();
  endtask : start_in
  task automatic power(input logic rc);
    pwr    = 1'b0;
    rc_pin = 1'b0;
    bus_on = 1'b0;
    repeat (8) @(negedge i_clock);
    rc_pin = rc;
    pwr    = 1'b1;
  endtask : power
  // ***************************
  // main sequence
  // ***************************
  initial begin
    err_total = 0;
    checks    = 0;
    i_reset   = 1'b1;
    {pwr, rc_pin, bus_on, is_dc} = 4'h0;
    fol_pin   = 1'b1;
    vin_rms   = 16'h00E6;
    vin_freq  = 16'h0032;
    repeat (4) @(negedge i_clock);
    i_reset = 1'b0;
    rd(CMD_RC_DELAY, 16'h0000);
    rd(CMD_VIN_DELAY, START_SPEC_MS);
    wr(CMD_VIN_DELAY, 16'h01F3, 1'b1);
    wr(CMD_VIN_DELAY, 16'hFA01, 1'b1);
    wr(CMD_VIN_DELAY, 16'hFA00, 1'b0);
    rd(CMD_VIN_DELAY, 16'hFA00);
    wr(CMD_VIN_DELAY, START_SPEC_MS, 1'b0);
    rd(CMD_FAN, 16'h0000);
    rd(CMD_ROLE_SEL, 16'h0000);
    rd(CMD_AUX, 16'h0078);
    wr(CMD_RC_DELAY, 16'h0F3C, 1'b0);
    wr(CMD_RC_DELAY, 16'h0F3D, 1'b1);
    rd(CMD_RC_DELAY, 16'h0F3C);
    wr(CMD_RC_DELAY, 16'h0000, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wr(CMD_SLEW, 16'h00FC | 16'(k), 1'b0);
      rd(CMD_SLEW, 16'(k));
      chk("slew out", 16'(k), {14'h0000, slew});
    end
    wr(CMD_FAN, 16'h00FF, 1'b0);
    rd(CMD_FAN, 16'h0001);
    chk("fan max", 16'h0001, {15'h0000, fan_max});
    wr(CMD_AC_START, 16'h0050, 1'b1);
    wr(CMD_AC_START, 16'h00F1, 1'b1);
    wr(CMD_AC_START, 16'h0051, 1'b0);
    wr(CMD_AC_STOP, 16'h004C, 1'b1);
    wr(CMD_AC_STOP, 16'h0031, 1'b1);
    rd(CMD_AC_STOP, 16'h004B);
    wr(CMD_AC_STOP, 16'h0032, 1'b0);
    rd(CMD_AC_START, 16'h0051);
    wr(CMD_DC_START, 16'h006E, 1'b1);
    wr(CMD_DC_START, 16'h0155, 1'b1);
    wr(CMD_DC_START, 16'h006F, 1'b0);
    wr(CMD_DC_STOP, 16'h0065, 1'b1);
    wr(CMD_DC_STOP, 16'h0045, 1'b1);
    wr(CMD_DC_STOP, 16'h0046, 1'b0);
    rd(CMD_DC_STOP, 16'h0046);
    wr(CMD_AUX, 16'h007F, 1'b1);
    wr(CMD_AUX, 16'h007E, 1'b0);
    // the setpoint output lags the register by one clock
    rd(CMD_AUX, 16'h007E);
    chk("aux out", 16'h007E, aux);
    wr(CMD_ROLE_SEL, 16'h00FD, 1'b0);
    rd(CMD_ROLE_SEL, 16'h0001);
    chk("ac start active", 16'h0055, ac_on);
    rd(CMD_VIN_MON, 16'h00E6);
    rd(CMD_FREQ_MON, 16'h0032);
    is_dc = 1'b1;
    rd(CMD_FREQ_MON, 16'h0000);
    is_dc = 1'b0;
    wr(CMD_VIN_MON, 16'h0000, 1'b1);
    cmd(1'b0, CMD_STORE_ALL, 16'h0000, 1'b1, 16'h0000);
    cmd(1'b0, 8'h00, 16'h0000, 1'b1, 16'h0000);
    // nothing stored yet: old thresholds and pin-chosen role
    power(1'b1);
    start_in(1200);
    chk("ac start kept", 16'h0055, ac_on);
    rd(CMD_ROLE_RB, 16'h0001);
    host.store(seen, err);
    chk("store error", 16'h0000, {15'h0000, err});
    wr(CMD_RC_DELAY, 16'h0F3C, 1'b0);
    power(1'b1);
    start_in(4600);
    chk("ac start", 16'h0051, ac_on);
    chk("ac stop", 16'h0032, ac_off);
    chk("dc start", 16'h006F, dc_on);
    chk("dc stop", 16'h0046, dc_off);
    chk("role slave", 16'h0000, {15'h0000, role_slave});
    rd(CMD_ROLE_RB, 16'h0000);
    wr(CMD_RC_DELAY, 16'h0064, 1'b0);
    power(1'b0);
    repeat (2400) @(negedge i_clock);
    rc_pin = 1'b1;
    start_in(100);
    rc_pin = 1'b0;
    repeat (8) @(negedge i_clock);
    chk("start off", 16'h0000, {15'h0000, out_start});
    bus_on = 1'b1;
    start_in(100);
    // forced slave must win over a pin that asks for master
    fol_pin = 1'b0;
    wr(CMD_ROLE_SEL, 16'h0003, 1'b0);
    host.store(seen, err);
    chk("store seen", 16'h0001, {15'h0000, seen});
    power(1'b0);
    repeat (8) @(negedge i_clock);
    chk("role forced", 16'h0001, {15'h0000, role_slave});
    rd(CMD_ROLE_RB, 16'h0001);
    results();
  end
endmodule : psc_config_regs_tb
`default_nettype wire
